//--- common/t1tx_pkg.sv
// shared constants and types for the t1 transmit framer
// assumes one core clock; every line-side pin is sampled synchronously to it
package t1tx_pkg;

	// ------------------------------------------------------------
	// frame geometry and pipeline
	// ------------------------------------------------------------
	localparam int        BITS_PER_FRAME = 193;
	localparam logic [7:0] LAST_BIT      = 8'hC0;  // bit 192
	localparam logic [4:0] LAST_CH       = 5'h17;  // channel 24
	localparam int        LINE_LATENCY   = 10;     // bit clocks from input to line
	localparam int        FIFO_DEPTH     = 32;
	localparam int        FIFO_WIDTH     = 1;

	// ------------------------------------------------------------
	// common_control field positions and reset
	// ------------------------------------------------------------
	localparam int CCR_LOOPBACK    = 0;
	localparam int CCR_SF_YEL      = 3;  // sf_yellow_format
	localparam int CCR_FM_LO       = 4;  // framing_select_low
	localparam int CCR_ESF_YEL     = 5;  // esf_yellow_format
	localparam int CCR_S2_SEL      = 6;  // status_bit2_select
	localparam int CCR_FM_HI       = 7;  // framing_select_high
	localparam logic [7:0] CCR_RESET = 8'h00;

	// ------------------------------------------------------------
	// transmit_control field positions and reset
	// ------------------------------------------------------------
	localparam int TCR_SEND_YEL    = 0;
	localparam int TCR_SEND_BLUE   = 1;
	localparam int TCR_S_EXT       = 2;
	localparam int TCR_ROBBED_BIT_SIGNALING_ENABLE        = 4;  // robbed_bit_signaling_enable
	localparam int TCR_CRC_EXT     = 5;
	localparam int TCR_FRAME_EXT   = 6;
	localparam int TCR_ODF         = 7;  // output_format
	localparam logic [7:0] TCR_RESET   = 8'h00;
	localparam logic [7:0] TCR_HW_MODE = 8'h10;

	// ------------------------------------------------------------
	// framing patterns and multiframe lengths
	// ------------------------------------------------------------
	localparam logic [6:0]  SF_LEN       = 7'h0C;
	localparam logic [6:0]  ESF_LEN      = 7'h18;
	localparam logic [6:0]  SLC_LEN      = 7'h48;
	localparam logic [5:0]  FT_PAT       = 6'h15;  // odd frames 1..11
	localparam logic [5:0]  FS_PAT       = 6'h1C;  // even frames 2..12
	localparam logic [5:0]  FPS_PAT      = 6'h34;  // frames 4..24
	localparam logic [15:0] ESF_YEL_PAT  = 16'h00FF;
	localparam logic [35:0] SLC_FS_PAT   = 36'h38000000E;
	localparam logic [2:0]  SLC_SPOILER  = 3'h2;
	localparam logic [5:0]  SLC_DL_FIRST = 6'h05;  // frame 12
	localparam logic [5:0]  SLC_DL_LAST  = 6'h1B;  // frame 56
	localparam logic [5:0]  SLC_SP_FIRST = 6'h10;
	localparam logic [5:0]  SLC_SP_LAST  = 6'h12;
	localparam logic [5:0]  CRC_POLY     = 6'h03;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		T1TX_FMT_SF  = 2'b00,
		T1TX_FMT_ESF = 2'b01,
		T1TX_FMT_SLC = 2'b10,
		T1TX_FMT_DDM = 2'b11
	} t1tx_fmt_t;

	typedef struct packed {
		logic chan_clk;
		logic multiframe;
		logic sig_select;
		logic sig_frame;
		logic link_clk;
	} t1tx_timing_t;

endpackage : t1tx_pkg

//--- design/t1tx_framer.sv
// t1 transmit framer: bit-clock edge detect, frame counters, insertion mux, line fifo, line coder
// assumes the bit clock and all data/sync pins are synchronous to core_clk_i and much slower
// Behaviour
// - superframe yellow: bit 2 zero in all channels, or S-bit of frame 12 one.
// - framing format comes from control bits 4 and 7; basic variant forces bit 7 low.
// - extended superframe yellow: 00FF pattern on facility link, or bit 2 zero.
// - receive status bit 2 shows B8ZS detect or frame alignment change by select bit.
// - sample inputs on bit clock falling edge; line output follows ten bit clocks later.
// - S-bits internal or from link; facility link from link; signaling from signaling input.
// - output format clear gives dual-unipolar, set gives NRZ with negative held low.
// - frame counters run on the bit clock and free-run without sync.
// - superframe sync edge makes next sampled bit the F-bit of frame one.
// - frame sync edge starts a new frame; superframe alignment moves forward minimally.
// - channel clock goes high at each channel start with half duty.
// - superframe: multiframe high at start, signaling frame every sixth, link clock odd frames.
// - superframe: select at twice multiframe rate; multiframe high for A, low for B.
// - extended: multiframe high for A and B, select high for A and C, link odd frames.
// - loop carrier: select high frames 58 to 11, data link accepted while low.
// - loop carrier: spoiler bits generated inside, link input ignored there.
// - loop carrier: multiframe rises at frame 6, falls at frame 12, every 12 frames.
// - digital data: link clock one bit per frame; channel 24 link sampled then.
// - hardware mode forces transmit control to zero except signaling enable.
// - send yellow per superframe or extended format, none in loop carrier, ch24 bit 5 otherwise.
// - blue alarm or loopback sends unframed all ones over everything else.
`timescale 1ns/1ps

// ------------------------------------------------------------
// line fifo
// ------------------------------------------------------------
module t1tx_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic [$clog2(DEPTH):0] count_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              do_push = in_valid_i & in_ready_o;
	wire              do_pop  = out_valid_o & out_ready_i;

	// honest flags from the occupancy count
	assign in_ready_o  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem[rd_ptr_reg];
	assign count_o     = count_reg;

	// storage
	always_ff @(posedge core_clk_i) begin
		if (do_push) mem[wr_ptr_reg] <= in_data_i;
	end

	// pointers and count
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (do_push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
			if (do_pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
			count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : t1tx_fifo

// ------------------------------------------------------------
// framer top
// ------------------------------------------------------------
module t1tx_framer import t1tx_pkg::*; #(
	parameter bit BASIC_VARIANT = 1'b0
) (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       hw_mode_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_sel_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       tx_bit_clock_i,
	input  wire logic       tx_channel_data_in_i,
	input  wire logic       tx_link_data_in_i,
	input  wire logic       tx_signaling_in_i,
	input  wire logic       tx_superframe_sync_in_i,
	input  wire logic       tx_frame_sync_in_i,
	input  wire logic       rx_b8zs_detect_i,
	input  wire logic       rx_frame_alignment_change_i,
	output logic [7:0]      common_control_o,
	output logic [7:0]      transmit_control_o,
	output logic            receive_status_bit2_o,
	output logic            tx_line_positive_o,
	output logic            tx_line_negative_o,
	output logic            tx_channel_clock_o,
	output logic            tx_multiframe_out_o,
	output logic            tx_signaling_select_o,
	output logic            tx_signaling_frame_o,
	output logic            tx_link_clock_o,
	output logic            tx_fifo_ready_o
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0] ccr_reg, tcr_reg, ccr_eff_reg, tcr_eff_reg;
	logic       bclk_reg, ms_last_reg, fs_last_reg, ms_pend_reg, fs_pend_reg;
	logic [7:0] bit_reg;
	logic [2:0] pos_reg, f6_reg;
	logic [4:0] ch_reg;
	logic [6:0] fr_reg;
	logic [3:0] f12_reg, yel_idx_reg;
	logic [5:0] crc_acc_reg, crc_last_reg;
	logic       ami_pol_reg;
	t1tx_timing_t tim_reg;
	logic       fifo_in_ready, fifo_out_valid, fifo_out_data;
	logic [5:0] fifo_count;

	// ------------------------------------------------------------
	// host control registers
	// ------------------------------------------------------------
	wire [7:0] ccr_wdata = BASIC_VARIANT ? {1'b0, reg_wdata_i[6:0]} : reg_wdata_i;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ccr_reg <= CCR_RESET;
			tcr_reg <= TCR_RESET;
		end else if (reg_wr_i) begin
			if (!reg_sel_i) ccr_reg <= ccr_wdata;
			else tcr_reg <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// bit clock edges and sync capture
	// ------------------------------------------------------------
	wire fall_stb = bclk_reg & ~tx_bit_clock_i;
	wire rise_stb = ~bclk_reg & tx_bit_clock_i;
	wire step     = fall_stb & fifo_in_ready;  // a full fifo stalls the framer
	wire ms_edge  = rise_stb & tx_superframe_sync_in_i & ~ms_last_reg;
	wire fs_edge  = rise_stb & tx_frame_sync_in_i & ~fs_last_reg;

	// sync edges are caught at the rising edge and used at the next falling edge
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			bclk_reg    <= 1'b0;
			ms_last_reg <= 1'b0;
			fs_last_reg <= 1'b0;
			ms_pend_reg <= 1'b0;
			fs_pend_reg <= 1'b0;
		end else begin
			bclk_reg <= tx_bit_clock_i;
			if (rise_stb) ms_last_reg <= tx_superframe_sync_in_i;
			if (rise_stb) fs_last_reg <= tx_frame_sync_in_i;
			ms_pend_reg <= ms_edge | (ms_pend_reg & ~step);
			fs_pend_reg <= fs_edge | (fs_pend_reg & ~step);
		end
	end

	// ------------------------------------------------------------
	// effective configuration, taken only on bit boundaries
	// ------------------------------------------------------------
	wire [7:0] tcr_src = hw_mode_i ? TCR_HW_MODE : tcr_reg;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ccr_eff_reg <= CCR_RESET;
			tcr_eff_reg <= TCR_RESET;
		end else if (fall_stb) begin
			ccr_eff_reg <= ccr_reg;
			tcr_eff_reg <= tcr_src;
		end
	end

	t1tx_fmt_t fmt;
	assign fmt = t1tx_fmt_t'({ccr_eff_reg[CCR_FM_HI], ccr_eff_reg[CCR_FM_LO]});
	wire is_sf  = (fmt == T1TX_FMT_SF);
	wire is_esf = (fmt == T1TX_FMT_ESF);
	wire is_slc = (fmt == T1TX_FMT_SLC);
	wire is_ddm = (fmt == T1TX_FMT_DDM);
	wire [6:0] mf_len = is_esf ? ESF_LEN : (is_slc ? SLC_LEN : SF_LEN);
	wire send_yel  = tcr_eff_reg[TCR_SEND_YEL];
	wire send_blue = tcr_eff_reg[TCR_SEND_BLUE] | ccr_eff_reg[CCR_LOOPBACK];
	wire s_ext     = tcr_eff_reg[TCR_S_EXT] & ~is_esf;
	wire robbed_bit_signaling_enable      = tcr_eff_reg[TCR_ROBBED_BIT_SIGNALING_ENABLE];
	wire f_ext     = tcr_eff_reg[TCR_FRAME_EXT];

	// ------------------------------------------------------------
	// frame counters for the bit now being sampled
	// ------------------------------------------------------------
	wire       wrap     = (bit_reg == LAST_BIT);
	wire       new_fr   = wrap | fs_pend_reg;
	wire [7:0] bit_cur  = (ms_pend_reg | new_fr) ? 8'h00 : bit_reg + 8'h01;
	wire       is_f     = (bit_cur == 8'h00);
	wire       ch_start = (bit_cur == 8'h01);
	wire [2:0] pos_cur  = ch_start ? 3'h0 : pos_reg + 3'h1;
	wire [4:0] ch_cur   = ch_start ? 5'h00 : ((pos_reg == 3'h7) ? ch_reg + 5'h01 : ch_reg);
	wire       fr_wrap  = (fr_reg >= mf_len - 7'h01);
	wire [6:0] fr_cur   = ms_pend_reg ? 7'h00 : (!new_fr ? fr_reg : (fr_wrap ? 7'h00 : fr_reg + 7'h01));
	wire [2:0] f6_cur   = ms_pend_reg ? 3'h0 : (!new_fr ? f6_reg : ((f6_reg == 3'h5) ? 3'h0 : f6_reg + 3'h1));
	wire [3:0] f12_cur  = ms_pend_reg ? 4'h0 : (!new_fr ? f12_reg : ((f12_reg == 4'hB) ? 4'h0 : f12_reg + 4'h1));
	wire       odd_fr   = ~fr_cur[0];
	wire [2:0] h12      = f12_cur[3:1];
	wire [5:0] h36      = fr_cur[6:1];
	wire       sig_fr   = (f6_cur == 3'h5);

	// counters free-run without sync pulses
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			bit_reg <= 8'h00;
			pos_reg <= 3'h0;
			ch_reg  <= 5'h00;
			fr_reg  <= 7'h00;
			f6_reg  <= 3'h0;
			f12_reg <= 4'h0;
		end else if (step) begin
			bit_reg <= bit_cur;
			pos_reg <= pos_cur;
			ch_reg  <= ch_cur;
			fr_reg  <= fr_cur;
			f6_reg  <= f6_cur;
			f12_reg <= f12_cur;
		end
	end

	// ------------------------------------------------------------
	// timing outputs
	// ------------------------------------------------------------
	wire ddm_link_slot = is_ddm & ~is_f & (ch_cur == LAST_CH) & (pos_cur == 3'h6);
	t1tx_timing_t tim_cur;
	assign tim_cur.chan_clk   = ~is_f & ~pos_cur[2];
	assign tim_cur.multiframe = is_esf ? (fr_cur < 7'h0C) :
		(is_slc ? (f12_cur >= 4'h5 && f12_cur <= 4'hA) : (f12_cur < 4'h6));
	assign tim_cur.sig_select = is_slc ? (fr_cur >= 7'h39 || fr_cur <= 7'h0A) :
		(is_esf ? (f12_cur < 4'h6) : (f6_cur < 3'h3));
	assign tim_cur.sig_frame  = sig_fr;
	assign tim_cur.link_clk   = is_ddm ? ddm_link_slot : odd_fr;

	// ------------------------------------------------------------
	// insertion mux
	// ------------------------------------------------------------
	wire data_i = tx_channel_data_in_i;
	wire link_i = tx_link_data_in_i;
	wire esf_fdl_yel = send_yel & ~ccr_eff_reg[CCR_ESF_YEL];
	wire esf_fdl = esf_fdl_yel ? ESF_YEL_PAT[4'hF - yel_idx_reg] : link_i;
	wire esf_f   = odd_fr ? esf_fdl :
		(fr_cur[1] ? (f_ext ? data_i : FPS_PAT[fr_cur[4:2]]) :
		(tcr_eff_reg[TCR_CRC_EXT] ? data_i : crc_last_reg[3'h5 - fr_cur[4:2]]));
	wire slc_dl  = (h36 >= SLC_DL_FIRST) && (h36 <= SLC_DL_LAST);
	wire slc_sp  = (h36 >= SLC_SP_FIRST) && (h36 <= SLC_SP_LAST);
	wire [1:0] sp_idx = 2'(h36 - SLC_SP_FIRST);
	wire slc_s   = slc_dl ? (slc_sp ? SLC_SPOILER[sp_idx] : link_i) : SLC_FS_PAT[h36];
	wire sf_yel_s = is_sf & send_yel & ccr_eff_reg[CCR_SF_YEL] & (f12_cur == 4'hB);
	wire int_s   = (is_slc ? slc_s : FS_PAT[h12]) | sf_yel_s | (f_ext & data_i);
	wire s_bit   = s_ext ? link_i : int_s;
	wire ft_bit  = f_ext ? data_i : FT_PAT[h12];
	wire f_bit   = is_esf ? esf_f : (odd_fr ? ft_bit : s_bit);
	wire yel_b2  = send_yel & (pos_cur == 3'h1) &
		((is_sf & ~ccr_eff_reg[CCR_SF_YEL]) | (is_esf & ccr_eff_reg[CCR_ESF_YEL]));
	wire ddm_yel = is_ddm & send_yel & (ch_cur == LAST_CH) & (pos_cur == 3'h4);
	wire rob     = robbed_bit_signaling_enable & sig_fr & (pos_cur == 3'h7) & ~is_ddm;
	wire ch_bit  = ddm_link_slot ? link_i : (rob ? tx_signaling_in_i : (data_i & ~yel_b2 & ~ddm_yel));
	wire comp_bit = send_blue | (is_f ? f_bit : ch_bit);

	// facility-link yellow index and crc over the superframe, frame bits counted as ones
	wire       crc_fb   = crc_acc_reg[5] ^ (is_f ? 1'b1 : comp_bit);
	wire [5:0] crc_next = {crc_acc_reg[4:0], 1'b0} ^ (crc_fb ? CRC_POLY : 6'h00);
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			yel_idx_reg  <= 4'h0;
			crc_acc_reg  <= 6'h00;
			crc_last_reg <= 6'h00;
		end else if (step) begin
			if (is_esf & is_f & odd_fr) yel_idx_reg <= yel_idx_reg + 4'h1;
			if (is_f && fr_cur == 7'h00) begin
				crc_last_reg <= crc_acc_reg;
				crc_acc_reg  <= 6'h00;
			end else begin
				crc_acc_reg <= crc_next;
			end
		end
	end

	// ------------------------------------------------------------
	// line fifo: primed to a fixed depth so the line lags the inputs exactly
	// ------------------------------------------------------------
	wire primed  = (fifo_count >= 6'(LINE_LATENCY));
	wire pop_stb = fall_stb & primed;
	t1tx_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (fall_stb),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (comp_bit),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop_stb),
		.out_data_o  (fifo_out_data),
		.count_o     (fifo_count)
	);

	// ------------------------------------------------------------
	// output registers and line coding
	// ------------------------------------------------------------
	wire nrz      = tcr_eff_reg[TCR_ODF];
	wire line_one = fifo_out_valid & fifo_out_data;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			tx_line_positive_o <= 1'b0;
			tx_line_negative_o <= 1'b0;
			ami_pol_reg        <= 1'b0;
		end else if (pop_stb) begin
			tx_line_positive_o <= line_one & (nrz | ~ami_pol_reg);
			tx_line_negative_o <= line_one & ~nrz & ami_pol_reg;
			if (line_one & ~nrz) ami_pol_reg <= ~ami_pol_reg;
		end
	end

	// timing, status and readback
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			tim_reg               <= '0;
			common_control_o      <= CCR_RESET;
			transmit_control_o    <= TCR_RESET;
			receive_status_bit2_o <= 1'b0;
			tx_fifo_ready_o       <= 1'b0;
		end else begin
			if (step) tim_reg <= tim_cur;
			common_control_o      <= ccr_reg;
			transmit_control_o    <= tcr_src;
			receive_status_bit2_o <= ccr_reg[CCR_S2_SEL] ? rx_frame_alignment_change_i : rx_b8zs_detect_i;
			tx_fifo_ready_o       <= fifo_in_ready;
		end
	end
	assign tx_channel_clock_o    = tim_reg.chan_clk;
	assign tx_multiframe_out_o   = tim_reg.multiframe;
	assign tx_signaling_select_o = tim_reg.sig_select;
	assign tx_signaling_frame_o  = tim_reg.sig_frame;
	assign tx_link_clock_o       = tim_reg.link_clk;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence step_s; step; endsequence
	sequence msync_step_s; step && ms_pend_reg; endsequence

	blue_all_ones_a: assert property (step_s and (step && send_blue) |-> comp_bit)
		else $error("blue alarm bit not one");
	nrz_neg_low_a: assert property ((pop_stb && nrz) |=> !tx_line_negative_o)
		else $error("negative line driven in nrz");
	msync_align_a: assert property (msync_step_s |=> (bit_reg == 8'h00 && fr_reg == 7'h00 && f12_reg == 4'h0))
		else $error("superframe sync did not align counters");
	fsync_align_a: assert property ((step && fs_pend_reg && !ms_pend_reg) |=> bit_reg == 8'h00)
		else $error("frame sync did not start frame");
	sig_frame_out_a: assert property ((step && f6_cur == 3'h5) |=> tx_signaling_frame_o)
		else $error("signaling frame output missing");
	chan_clk_high_a: assert property ((step && !is_f && pos_cur < 3'h4) |=> tx_channel_clock_o)
		else $error("channel clock low in first half");
	sf_yel_bit2_a: assert property ((step && is_sf && send_yel && !ccr_eff_reg[CCR_SF_YEL]
		&& !is_f && pos_cur == 3'h1 && !send_blue) |-> !comp_bit)
		else $error("superframe yellow bit 2 not zero");
	hw_mode_tcr_a: assert property ((fall_stb && hw_mode_i) |=> tcr_eff_reg == TCR_HW_MODE)
		else $error("hardware mode control not forced");
	ddm_link_a: assert property ((step && ddm_link_slot && !send_blue) |-> comp_bit == tx_link_data_in_i)
		else $error("channel 24 link bit not taken");
	fifo_prime_a: assert property (pop_stb |-> fifo_count == 6'(LINE_LATENCY) ##1 fifo_count <= 6'(LINE_LATENCY))
		else $error("line latency not held");
endmodule : t1tx_framer

//--- bench/t1tx_line_model.sv
// line-side partner: free-running bit clock, pattern sources and superframe sync pulses
// assumes core_clk_i is the framer clock; one bit lasts four core cycles
`timescale 1ns/1ps
module t1tx_line_model (
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	input  wire logic sync_req_i,
	output logic      bit_clk_o,
	output logic      data_o,
	output logic      link_o,
	output logic      sig_o,
	output logic      msync_o,
	output logic      tick_o,
	output logic      smp_data_o,
	output logic      smp_f_o
);
	logic [1:0]  ph_reg;
	logic [7:0]  idx_reg;
	logic [15:0] pat_reg;
	logic        pend_reg;
	// clock high in phases 0-1, low in 2-3; sources move only at the rise so the fall sees stable data
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ph_reg   <= 2'h0;
			idx_reg  <= 8'h00;
			pat_reg  <= 16'hACE1;
			pend_reg <= 1'b0;
			{bit_clk_o, data_o, link_o, sig_o, msync_o, tick_o, smp_data_o, smp_f_o} <= 8'h80;
		end else begin
			ph_reg   <= ph_reg + 2'h1;
			tick_o   <= (ph_reg == 2'h0);
			pend_reg <= pend_reg | sync_req_i;
			if (ph_reg == 2'h1) bit_clk_o <= 1'b0;
			if (ph_reg == 2'h2) begin
				smp_data_o <= data_o;            // copy of the bit the framer just took
				smp_f_o    <= (idx_reg == 8'h00);
				msync_o    <= pend_reg;          // rises one core cycle ahead of the bit clock rise
			end
			if (ph_reg == 2'h3) begin
				bit_clk_o <= 1'b1;
				pat_reg   <= {pat_reg[14:0], pat_reg[15] ^ pat_reg[13] ^ pat_reg[12] ^ pat_reg[10]};
				{data_o, link_o, sig_o} <= {pat_reg[15], pat_reg[7], pat_reg[3]};
				idx_reg   <= (msync_o || idx_reg == 8'hC0) ? 8'h00 : idx_reg + 8'h01;
				if (msync_o) pend_reg <= 1'b0;
			end
		end
	end
endmodule : t1tx_line_model

//--- bench/t1tx_framer_tb.sv
// self-checking bench for the t1 transmit framer
// assumes the line model gives a free-running bit clock at a quarter of the core rate
`timescale 1ns/1ps
module t1tx_framer_tb import t1tx_pkg::*;;
	logic core_clk_i, resetn_i, hw_mode, reg_wr, reg_sel, b8zs, frame_alignment_change, fsync, sync_req, prev;
	logic [7:0] reg_wdata, ccr_o, tcr_o;
	logic bclk, tdat, tx_link_data_in, tsig, msync, tick, sdat, sf, s2, pos, neg, chclk, mf, ssel, sfr, lclk, frdy;
	logic h [0:10];
	logic hf [0:10];
	int err_total, checked;
	t1tx_timing_t tim;
	assign tim = '{chclk, mf, ssel, sfr, lclk};
	// ------------------------------------------------------------
	// design and partner
	// ------------------------------------------------------------
	t1tx_framer #(.BASIC_VARIANT(1'b0)) u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .hw_mode_i(hw_mode),
		.reg_wr_i(reg_wr), .reg_sel_i(reg_sel), .reg_wdata_i(reg_wdata), .tx_bit_clock_i(bclk),
		.tx_channel_data_in_i(tdat), .tx_link_data_in_i(tx_link_data_in), .tx_signaling_in_i(tsig),
		.tx_superframe_sync_in_i(msync), .tx_frame_sync_in_i(fsync), .rx_b8zs_detect_i(b8zs),
		.rx_frame_alignment_change_i(frame_alignment_change), .common_control_o(ccr_o), .transmit_control_o(tcr_o),
		.receive_status_bit2_o(s2), .tx_line_positive_o(pos), .tx_line_negative_o(neg),
		.tx_channel_clock_o(chclk), .tx_multiframe_out_o(mf), .tx_signaling_select_o(ssel),
		.tx_signaling_frame_o(sfr), .tx_link_clock_o(lclk), .tx_fifo_ready_o(frdy));
	t1tx_line_model u_line (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .sync_req_i(sync_req),
		.bit_clk_o(bclk), .data_o(tdat), .link_o(tx_link_data_in), .sig_o(tsig), .msync_o(msync), .tick_o(tick),
		.smp_data_o(sdat), .smp_f_o(sf));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			err_total++;
		end
	endtask : check
	task give_verdict;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	task time_out;
		err_total++;
		give_verdict;
	endtask : time_out
	// wait for the next bit and keep the history of sampled bits
	task next_bit;
		int n;
		for (n = 0; n < 16 && tick !== 1'b1; n++) @(posedge core_clk_i);
		if (tick !== 1'b1) time_out;
		for (n = 10; n > 0; n--) begin
			h[n] = h[n-1];
			hf[n] = hf[n-1];
		end
		h[0] = sdat;
		hf[0] = sf;
		@(posedge core_clk_i);
	endtask : next_bit
	task wr_reg(input logic sel, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_sel <= sel;
		reg_wdata <= d;
		@(posedge core_clk_i);
		reg_wr <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask : wr_reg
	// request a superframe sync and stop at the first frame bit after it
	task do_sync;
		int n;
		sync_req <= 1'b1;
		@(posedge core_clk_i);
		sync_req <= 1'b0;
		for (n = 0; n < 16 && msync !== 1'b1; n++) @(posedge core_clk_i);
		for (n = 0; n < 4 && sf !== 1'b1; n++) next_bit;
		if (sf !== 1'b1) time_out;
	endtask : do_sync
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset_regs;
		check(ccr_o, 8'h00);
		check(tcr_o, 8'h00);
		check({pos, neg, frdy}, 3'h1);
		wr_reg(1'b0, 8'h6D);
		check(ccr_o, 8'h6D);
		hw_mode <= 1'b1;
		wr_reg(1'b1, 8'h83);
		check(tcr_o, 8'h10);
		hw_mode <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		check(tcr_o, 8'h83);
		wr_reg(1'b1, 8'h00);
		b8zs <= 1'b1;
		wr_reg(1'b0, 8'h00);
		check(s2, 1'b1);
		wr_reg(1'b0, 8'h40);
		check(s2, 1'b0);
		frame_alignment_change <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		check(s2, 1'b1);
		$display("test regs done");
	endtask : t_reset_regs
	task t_sync;
		wr_reg(1'b0, 8'h00);
		do_sync;
		check({mf, lclk}, 2'h3);
		next_bit;
		check(chclk, 1'b1);
		repeat (4) next_bit;
		check(chclk, 1'b0);
		repeat (188) next_bit;
		check({mf, lclk}, 2'h2);
		repeat (772) next_bit;
		check(sfr, 1'b1);
		repeat (193) next_bit;
		check({mf, sfr}, 2'h0);
		$display("test sync done");
	endtask : t_sync
	// frame sync in mid-frame: the next sampled bit becomes a frame bit of the following frame
	task t_fsync;
		repeat (50) next_bit;
		fsync <= 1'b1;
		next_bit;
		fsync <= 1'b0;
		next_bit;
		check({chclk, lclk}, 2'h0);
		repeat (4) next_bit;
		check(chclk, 1'b1);
		$display("test fsync done");
	endtask : t_fsync
	task t_period(input logic [7:0] common_control, input int p, input int exp_bits);
		int n;
		int k;
		wr_reg(1'b0, common_control);
		prev = 1'b1;
		for (n = 0; n < 9300 && !(prev === 1'b0 && tim[p] === 1'b1); n++) begin
			prev = tim[p];
			next_bit;
		end
		if (n == 9300) time_out;
		for (k = 0; k == 0 || (k < 9300 && !(prev === 1'b0 && tim[p] === 1'b1)); k++) begin
			prev = tim[p];
			next_bit;
		end
		check(16'(k), 16'(exp_bits));
		$display("test period done");
	endtask : t_period
	task t_line(input logic [7:0] transmit_control);
		int n;
		logic e;
		wr_reg(1'b1, transmit_control);
		do_sync;
		for (n = 0; n < 200; n++) begin
			next_bit;
			if (n > 20 && transmit_control[1]) check(pos | neg, 1'b1);
			e = h[10] & !(transmit_control[0] && (n - 9) % 8 == 2);
			if (n > 20 && !transmit_control[1] && !hf[10]) check(transmit_control[7] ? pos : pos | neg, e);
			if (n > 20) check(transmit_control[7] ? neg : pos & neg, 1'b0);
		end
		$display("test line done");
	endtask : t_line
	// ------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	initial begin
		{resetn_i, hw_mode, reg_wr, reg_sel, b8zs, frame_alignment_change, fsync, sync_req} = 8'h00;
		reg_wdata = 8'h00;
		err_total = 0;
		checked = 0;
		repeat (3) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		t_reset_regs;
		t_sync;
		t_fsync;
		t_period(8'h00, 3, 2316);
		t_period(8'h00, 2, 1158);
		t_period(8'h10, 3, 4632);
		t_period(8'h10, 2, 2316);
		t_period(8'h90, 0, 193);
		wr_reg(1'b0, 8'h00);
		t_line(8'h00);
		t_line(8'h80);
		t_line(8'h02);
		t_line(8'h82);
		t_line(8'h01);
		give_verdict;
	end
endmodule : t1tx_framer_tb
